/* verilog/supply_monitor_pkg.sv */
// Package with register map, field layout and timing for the supply monitor
package supply_monitor_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] addr_control   = 8'h00;
    localparam logic [7:0] addr_status    = 8'h04;
    localparam logic [7:0] addr_irq_mask  = 8'h08;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int ctl_level_lsb  = 0;
    localparam int ctl_level_w    = 4;
    localparam int ctl_enable_bit = 4;
    localparam int ctl_refok_bit  = 5;
    localparam int ctl_bgok_bit   = 6;
    localparam int ctl_dir_bit    = 7;
    localparam logic [7:0] ctl_reset      = 8'h00;
    localparam logic [7:0] ctl_write_mask = 8'h9F;
    localparam logic [3:0] level_external = 4'hF;

    // ------------------------------------------------------------
    // Status and mask bits
    // ------------------------------------------------------------
    localparam int st_event_bit = 0;
    localparam int st_w         = 1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int clock_mhz        = 250;
    localparam int settle_time_us   = 20;
    localparam int settle_cycles    = settle_time_us * clock_mhz;

    // AXI responses
    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

endpackage : supply_monitor_pkg

/* verilog/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync #(
    parameter logic reset_value = 1'b0
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic pin,
    output logic      level
);
    logic stage1;
    logic stage2;
    logic stage3;

    // ------------------------------------------------------------
    // Synchroniser chain
    // ------------------------------------------------------------
    // Stage one feeds only stage two
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= reset_value;
            stage2 <= reset_value;
            stage3 <= reset_value;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Change counts once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level <= reset_value;
        end else if (stage2 == stage3) begin
            level <= stage3;
        end
    end
endmodule : pin_sync

/* verilog/supply_monitor.sv */
// Supply excursion detector control, flags and AXI4-Lite registers
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns

// Behaviour
// R1 - Comparator and divider powered only while monitor_enable is set
// R2 - reference_stable low until settled; no event flag before it is high
// R3 - Direction clear detects falling supply, set detects rising supply
// R4 - Four-bit trip_level_select picks one of sixteen trip points
// R5 - Code all ones routes external_trip_input to the comparator
// R6 - Trip in selected direction sets sticky supply_event_flag
// R7 - Software needs both interrupt enables for a vectored interrupt
// R8 - Software sets level, direction, enable, clears stale flag, then irq
// R9 - Software disables before changing direction or trip level
// R10 - bandgap_stable read-only at bit 6; writes to status bits ignored
// R11 - Detector keeps working in sleep; trip sets flag and wakes device
// R12 - Reset returns control register to reset value, detector off
// R13 - Settling counter starts on enable rise, clears with enable
// R14 - Trip result synchronised and edge-qualified, one flag per crossing
module supply_monitor
    import supply_monitor_pkg::*;
#(
    parameter int settle_count = settle_cycles
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Analog side
    input  wire logic        comparator_trip,
    input  wire logic        bandgap_ready,
    input  wire logic        external_trip_input,
    output logic             detector_power,
    output logic [3:0]       divider_tap,
    output logic             external_select,
    output logic             direction_select,
    // System side
    input  wire logic        sleep_mode,
    output logic             wake_request,
    output logic             irq
);
    import supply_monitor_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        settle_off     = 3'b001,
        settle_waiting = 3'b010,
        settle_done    = 3'b100
    } settle_state_type;

    settle_state_type settle_state;
    settle_state_type next_settle_state;

    logic [7:0]  control;
    logic [31:0] settle_counter;
    logic        reference_stable;
    logic        bandgap_stable;
    logic        trip_sync;
    logic        trip_prev;
    logic        trip_rise;
    logic        ext_level;
    logic [st_w-1:0] status;
    logic [st_w-1:0] irq_mask;
    logic        enable_prev;

    logic        have_aw;
    logic        have_w;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        write_fire;
    logic        ctl_write;
    logic        status_write;
    logic        addr_ok_w;

    logic        monitor_enable;
    logic [3:0]  trip_level_select;

    assign monitor_enable    = control[ctl_enable_bit];
    assign trip_level_select = control[ctl_level_lsb +: ctl_level_w];

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Comparator result into core clock domain
    pin_sync #(.reset_value(1'b0)) trip_sync_inst (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (comparator_trip),
        .level   (trip_sync)
    ); // [R14]

    // Bandgap ready flag
    pin_sync #(.reset_value(1'b0)) bandgap_sync_inst (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (bandgap_ready),
        .level   (bandgap_stable)
    );

    // External trip pin, observed for status only
    pin_sync #(.reset_value(1'b0)) ext_sync_inst (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (external_trip_input),
        .level   (ext_level)
    );

    // ------------------------------------------------------------
    // Analog steering
    // ------------------------------------------------------------
    // Power, tap selection and direction towards comparator
    always_comb begin
        detector_power   = monitor_enable; // [R1]
        divider_tap      = trip_level_select; // [R4]
        external_select  = monitor_enable
                         && (trip_level_select == level_external); // [R5]
        direction_select = control[ctl_dir_bit]; // [R3]
    end

    // ------------------------------------------------------------
    // Settling sequence
    // ------------------------------------------------------------
    // Enable edge tracker
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_prev <= 1'b0;
        end else begin
            enable_prev <= monitor_enable;
        end
    end

    // Next settle state
    always_comb begin
        next_settle_state = settle_state;
        case (settle_state)
            settle_off: begin
                if (monitor_enable && !enable_prev) begin
                    next_settle_state = settle_waiting; // [R13]
                end
            end
            settle_waiting: begin
                if (!monitor_enable) begin
                    next_settle_state = settle_off; // [R13]
                end else if (settle_counter >= 32'(settle_count - 1)) begin
                    next_settle_state = settle_done;
                end
            end
            settle_done: begin
                if (!monitor_enable) begin
                    next_settle_state = settle_off;
                end
            end
            default: next_settle_state = settle_off;
        endcase
    end

    // Settle state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            settle_state <= settle_off;
        end else begin
            settle_state <= next_settle_state;
        end
    end

    // Settle counter, runs only while waiting
    always_ff @(posedge aclk) begin
        if (!aresetn || settle_state != settle_waiting) begin
            settle_counter <= 32'h0000_0000; // [R13]
        end else begin
            settle_counter <= settle_counter + 32'h0000_0001;
        end
    end

    // Stable flag follows settle completion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reference_stable <= 1'b0;
        end else begin
            reference_stable <= (next_settle_state == settle_done); // [R2]
        end
    end

    // ------------------------------------------------------------
    // Trip detection
    // ------------------------------------------------------------
    // Previous trip level for edge qualification
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trip_prev <= 1'b0;
        end else begin
            trip_prev <= trip_sync;
        end
    end

    // Comparator reports crossing in selected direction as high level
    assign trip_rise = trip_sync && !trip_prev && monitor_enable
                     && reference_stable; // [R14] [R2] [R3]

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    assign s_axi_awready = !have_aw && !s_axi_bvalid;
    assign s_axi_wready  = !have_w && !s_axi_bvalid;
    assign write_fire    = have_aw && have_w && !s_axi_bvalid;
    assign addr_ok_w     = (aw_addr == addr_control)
                         || (aw_addr == addr_status)
                         || (aw_addr == addr_irq_mask);
    assign ctl_write     = write_fire && (aw_addr == addr_control)
                         && w_strb[0];
    assign status_write  = write_fire && (aw_addr == addr_status)
                         && w_strb[0];

    // Capture write address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            have_aw <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            have_aw <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (write_fire) begin
            have_aw <= 1'b0;
        end
    end

    // Capture write data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            have_w <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            have_w <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (write_fire) begin
            have_w <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= resp_okay;
        end else if (write_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_ok_w ? resp_okay : resp_slverr;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Control register; read-only bits never stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control <= ctl_reset; // [R12]
        end else if (ctl_write) begin
            control <= w_data[7:0] & ctl_write_mask; // [R10]
        end
    end

    // Interrupt mask register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask <= '0;
        end else if (write_fire && aw_addr == addr_irq_mask && w_strb[0]) begin
            irq_mask <= w_data[st_w-1:0];
        end
    end

    // Sticky event flag, set wins over write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= '0;
        end else if (trip_rise) begin
            status[st_event_bit] <= 1'b1; // [R6] [R11]
        end else if (status_write && w_data[st_event_bit]) begin
            status[st_event_bit] <= 1'b0;
        end
    end

    // Interrupt level and wake request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq          <= 1'b0;
            wake_request <= 1'b0;
        end else begin
            irq          <= |(status & irq_mask);
            wake_request <= sleep_mode && status[st_event_bit]; // [R11]
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    // Read data register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= resp_okay;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= resp_okay;
            case (s_axi_araddr)
                addr_control: begin
                    s_axi_rdata <= {24'h000000, control[ctl_dir_bit],
                                    bandgap_stable, reference_stable,
                                    control[ctl_enable_bit:ctl_level_lsb]
                                   }; // [R10] [R2]
                end
                addr_status: begin
                    s_axi_rdata <= {30'h0000_0000, ext_level, status};
                end
                addr_irq_mask: begin
                    s_axi_rdata <= {31'h0000_0000, irq_mask};
                end
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= resp_slverr;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : supply_monitor

/* bench/supply_monitor_checker.sv */
// Port-level concurrent checks for the supply monitor
`timescale 1ns/1ns
module supply_monitor_checker
    import supply_monitor_pkg::*;
#(
    parameter int settle_count = 8
) (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       detector_power,
    input wire logic [3:0] divider_tap,
    input wire logic       external_select,
    input wire logic       direction_select,
    input wire logic       sleep_mode,
    input wire logic       wake_request,
    input wire logic       irq
);
    int on_cnt;

    // --------------------------------------------
    // Cycles the detector has been powered
    // --------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || !detector_power) begin
            on_cnt <= 0;
        end else if (on_cnt < settle_count) begin
            on_cnt <= on_cnt + 1;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Both write channels taken, write data taken, and read address taken
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence wr_seen;
        s_axi_wvalid && s_axi_wready;
    endsequence

    chk_reset_idle: assert property (
        $rose(aresetn) |-> !detector_power && !irq && !wake_request)
        else $error("outputs not idle after reset");
    chk_ext_select: assert property (
        external_select == (detector_power && divider_tap == level_external))
        else $error("external select mismatch");
    chk_tap_written: assert property (
        $changed(divider_tap) |-> $past(s_axi_wvalid && s_axi_wready)
            || $past(s_axi_wvalid && s_axi_wready, 2))
        else $error("trip tap changed without a write");
    chk_dir_written: assert property (
        $changed(direction_select) |-> $past(s_axi_wvalid, 2)
            || $past(s_axi_wvalid))
        else $error("direction changed without a write");
    chk_wake_sleep: assert property (
        wake_request |-> $past(sleep_mode))
        else $error("wake without sleep");
    chk_flag_settled: assert property (
        $rose(wake_request) && $past(sleep_mode) && $past(sleep_mode, 2)
            |-> on_cnt >= settle_count - 2)
        else $error("event flagged before reference settled");
    chk_write_answer: assert property (
        wr_both |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    chk_read_answer: assert property (
        rd_taken |-> ##[1:2] s_axi_rvalid)
        else $error("read data late");
    chk_write_refused: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    chk_read_refused: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
endmodule : supply_monitor_checker

bind supply_monitor supply_monitor_checker #(
    .settle_count(settle_count)
) u_supply_monitor_checker (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .detector_power, .divider_tap, .external_select,
    .direction_select, .sleep_mode, .wake_request, .irq
);

/* bench/supply_monitor_test.sv */
// Self-checking bench for the supply monitor
`timescale 1ns/1ns
module supply_monitor_test;
    import supply_monitor_pkg::*;
    localparam int settle = 40;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, comparator_trip;
    logic bandgap_ready, external_trip_input, detector_power;
    logic external_select, direction_select, sleep_mode;
    logic wake_request, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, d;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0]  s_axi_wstrb, divider_tap;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] seed;
    int miscompares, comparisons;

    supply_monitor #(.settle_count(settle)) u_supply_monitor (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .comparator_trip, .bandgap_ready,
        .external_trip_input, .detector_power, .divider_tap,
        .external_select, .direction_select, .sleep_mode, .wake_request,
        .irq
    );

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // --------------------------------------------
    // Helpers
    // --------------------------------------------
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // Control readback: writable bits plus live bandgap bit, reference bit low
    function automatic logic [31:0] ctl_exp(logic [7:0] v, logic bg);
        return {24'h0, (v & ctl_write_mask) | {1'b0, bg, 6'h00}};
    endfunction : ctl_exp

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(int k);
        repeat (k) @(posedge aclk);
    endtask : cyc

    // Register write, both channels offered together
    task automatic wr(logic [7:0] a, logic [31:0] v);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        chk(s_axi_bvalid, 1'b1);
        chk(s_axi_bresp, resp_okay);
    endtask : wr

    // Register read, data left in rdat
    task automatic rd(logic [7:0] a, logic [1:0] rs);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        chk(s_axi_rvalid, 1'b1);
        rdat = s_axi_rdata;
        chk(s_axi_rresp, rs);
    endtask : rd

    task conclude;
        if (miscompares == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (5000) @(posedge aclk);
        miscompares++;
        conclude();
    end

    // --------------------------------------------
    // Main sequence
    // --------------------------------------------
    initial begin
        // Response readies stay high for the whole run
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h1;
        {s_axi_arvalid, s_axi_rready, aresetn} = 3'h2;
        {comparator_trip, bandgap_ready, external_trip_input} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        sleep_mode = 1'b0;
        seed = 16'h379C;
        miscompares = 0;
        comparisons = 0;
        cyc(2);
        aresetn <= 1'b1;
        cyc(1);
        rd(addr_control, resp_okay);
        chk(rdat, 32'h0);
        rd(addr_irq_mask, resp_okay);
        chk(rdat, 32'h0);
        rd(8'h0C, resp_slverr);
        chk(rdat, 32'h0);
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            bandgap_ready <= seed[0];
            external_trip_input <= seed[2];
            d = {seed[1], 2'b11, 1'b0, i[3:0]};
            cyc(8);
            wr(addr_control, {24'h0, d});
            chk(divider_tap, i[3:0]);
            chk(direction_select, d[7]);
            chk({detector_power, external_select}, 2'b00);
            rd(addr_control, resp_okay);
            chk(rdat, ctl_exp(d, seed[0]));
            rd(addr_status, resp_okay);
            chk(rdat, {30'h0, seed[2], 1'b0});
            wr(addr_control, {24'h0, d | 8'h10});
            chk(external_select, i == 15);
            chk(detector_power, 1'b1);
            wr(addr_control, {24'h0, d});
        end
        // Trip before the reference settles is lost
        wr(addr_control, 32'h13);
        comparator_trip <= 1'b1;
        cyc(8);
        comparator_trip <= 1'b0;
        rd(addr_control, resp_okay);
        chk(rdat[5], 1'b0);
        rd(addr_status, resp_okay);
        chk(rdat[0], 1'b0);
        cyc(2 * settle);
        rd(addr_control, resp_okay);
        chk(rdat[5], 1'b1);
        wr(addr_status, 32'h1);
        wr(addr_irq_mask, 32'h0);
        comparator_trip <= 1'b1;
        cyc(10);
        rd(addr_status, resp_okay);
        chk(rdat[0], 1'b1);
        chk(irq, 1'b0);
        wr(addr_irq_mask, 32'h1);
        cyc(2);
        chk(irq, 1'b1);
        // Clear while trip stays high: no second event
        wr(addr_status, 32'h1);
        cyc(10);
        rd(addr_status, resp_okay);
        chk({rdat[0], irq}, 2'b00);
        comparator_trip <= 1'b0;
        sleep_mode <= 1'b1;
        cyc(6);
        comparator_trip <= 1'b1;
        cyc(10);
        chk({wake_request, irq}, 2'b11);
        wr(addr_control, 32'h03);
        chk(detector_power, 1'b0);
        rd(addr_control, resp_okay);
        chk(rdat[5], 1'b0);
        wr(addr_status, 32'h1);
        comparator_trip <= 1'b0;
        cyc(6);
        comparator_trip <= 1'b1;
        cyc(10);
        rd(addr_status, resp_okay);
        chk(rdat[0], 1'b0);
        // Reset in mid-run
        wr(addr_control, 32'h13);
        aresetn <= 1'b0;
        cyc(2);
        aresetn <= 1'b1;
        cyc(1);
        rd(addr_control, resp_okay);
        chk(rdat & 32'hBF, 32'h0);
        conclude();
    end
endmodule : supply_monitor_test
